// ==== pkg/itc_pkg.sv ====
// Constants, field layout and types of the instruction cycle timing core
// Assumes one system clock domain and no software-visible register bus
// Notes on behaviour
// - One instruction cycle spans four system clocks
// - Plain instructions finish in one cycle
// - Jump, call, returns, table read take two
// - Writing program counter low byte jumps, +1 cycle
// - Taken skip costs one extra cycle
// - Skip bypasses next instruction when test holds
// - Logical results set zero flag when zero
// - Add carries past 255, subtract flags borrow
// - Increment/decrement by one, to memory or accumulator
// - Rotate one bit; through-carry variants use carry
// - Bit set/clear touches only addressed bit
// - Return resumes after call; jump saves nothing
// - Moves: memory-to-acc, acc-to-memory, immediate-to-acc
// - Bit index selects positions zero to seven
package itc_pkg;
   localparam int PC_W        = 11;
   localparam int DATA_W      = 8;
   localparam int INSTR_W     = 16;
   localparam int PHASES      = 4;
   localparam int STACK_DEPTH = 4;

   // Instruction word fields
   localparam int OP_MSB  = 15;
   localparam int OP_LSB  = 11;
   localparam int DEST_POS = 10;
   localparam int SUB_MSB = 10;
   localparam int SUB_LSB = 8;
   localparam int BIT_MSB = 10;
   localparam int BIT_LSB = 8;
   localparam int IMM_MSB = 7;
   localparam int IMM_LSB = 0;

   // Data addresses decoded inside the core
   localparam logic [7:0] PC_LOW_ADDR  = 8'h06;
   localparam logic [7:0] TBL_PTR_ADDR = 8'h07;
   localparam logic [7:0] TBL_HI_ADDR  = 8'h08;

   // Reset values
   localparam logic [10:0] PC_RST   = 11'h000;
   localparam logic [7:0]  DATA_RST = 8'h00;
   localparam logic [15:0] NOP_WORD = 16'h0000;

   // System sub-codes of the zero opcode
   localparam logic [2:0] SYS_NOP        = 3'h0;
   localparam logic [2:0] SYS_RETURN     = 3'h1;
   localparam logic [2:0] SYS_INT_RETURN = 3'h2;
   localparam logic [2:0] SYS_TABLE_READ = 3'h3;
   localparam logic [2:0] SYS_RETURN_IMM = 3'h4;

   typedef enum logic [4:0] {
      OP_SYS = 5'h00, OP_MOVE_TO_ACC = 5'h01, OP_MOVE_TO_MEM = 5'h02,
      OP_MOVE_IMM = 5'h03, OP_ADD = 5'h04, OP_ADDC = 5'h05, OP_SUB = 5'h06,
      OP_SUBC = 5'h07, OP_AND = 5'h08, OP_OR = 5'h09, OP_XOR = 5'h0A,
      OP_COMPL = 5'h0B, OP_INC = 5'h0C, OP_DEC = 5'h0D, OP_ROT_R = 5'h0E,
      OP_ROT_L = 5'h0F, OP_ROT_RC = 5'h10, OP_ROT_LC = 5'h11,
      OP_ADD_IMM = 5'h12, OP_SUB_IMM = 5'h13, OP_AND_IMM = 5'h14,
      OP_OR_IMM = 5'h15, OP_XOR_IMM = 5'h16, OP_BIT_CLR = 5'h17,
      OP_BIT_SET = 5'h18, OP_SKIP_BIT_ZERO = 5'h19, OP_SKIP_BIT_SET = 5'h1A,
      OP_SKIP_ZERO = 5'h1B, OP_SKIP_INC_ZERO = 5'h1C,
      OP_SKIP_DEC_ZERO = 5'h1D, OP_JUMP = 5'h1E, OP_CALL = 5'h1F
   } itc_op_t;

   // One-hot phase of the instruction cycle
   typedef enum logic [3:0] {
      PH0 = 4'h1, PH1 = 4'h2, PH2 = 4'h4, PH3 = 4'h8
   } itc_phase_t;
endpackage : itc_pkg

// ==== hdl/itc_phase_gen.sv ====
// Four-phase divider of the system clock
// Assumes clk is the system clock and nrst the device reset
`timescale 1ns/1ps
module itc_phase_gen (
   input  wire logic          clk,
   input  wire logic          nrst,
   output itc_pkg::itc_phase_t phase
);
   ////////////////////////////////////////////////////////////////////////
   // Phase ring, one full turn per instruction cycle
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         phase <= itc_pkg::PH0;
      end else begin
         case (phase)
            itc_pkg::PH0: phase <= itc_pkg::PH1;
            itc_pkg::PH1: phase <= itc_pkg::PH2;
            itc_pkg::PH2: phase <= itc_pkg::PH3;
            itc_pkg::PH3: phase <= itc_pkg::PH0;
            default:      phase <= itc_pkg::PH0;
         endcase
      end
   end
endmodule : itc_phase_gen

// ==== hdl/itc_alu.sv ====
// Combinational data path of the core: arithmetic, logic, rotate, bits
// Assumes operands are stable for a whole phase
`timescale 1ns/1ps
module itc_alu (
   input  itc_pkg::itc_op_t  op,
   input  wire logic [7:0]   acc,
   input  wire logic [7:0]   mem,
   input  wire logic [7:0]   imm,
   input  wire logic [2:0]   bitIdx,
   input  wire logic         carryIn,
   output logic [7:0]        result,
   output logic              carryOut
);
   logic [7:0] rhs;
   logic [8:0] wide;
   logic [7:0] mask;

   ////////////////////////////////////////////////////////////////////////
   // Operand select and one-hot bit mask
   always_comb begin
      rhs  = mem;
      mask = 8'h01 << bitIdx;
      if (op == itc_pkg::OP_ADD_IMM || op == itc_pkg::OP_SUB_IMM ||
          op == itc_pkg::OP_AND_IMM || op == itc_pkg::OP_OR_IMM ||
          op == itc_pkg::OP_XOR_IMM) begin
         rhs = imm;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Result and carry per operation
   always_comb begin
      wide     = 9'h000;
      result   = mem;
      carryOut = carryIn;
      case (op)
         itc_pkg::OP_SYS:         result = imm;
         itc_pkg::OP_MOVE_TO_ACC: result = mem;
         itc_pkg::OP_MOVE_TO_MEM: result = acc;
         itc_pkg::OP_MOVE_IMM:    result = imm;
         itc_pkg::OP_ADD, itc_pkg::OP_ADD_IMM, itc_pkg::OP_ADDC: begin
            wide = {1'b0, acc} + {1'b0, rhs};
            if (op == itc_pkg::OP_ADDC) begin
               wide = wide + {8'h00, carryIn};
            end
            result   = wide[7:0];
            carryOut = wide[8];
         end
         itc_pkg::OP_SUB, itc_pkg::OP_SUB_IMM, itc_pkg::OP_SUBC: begin
            wide = {1'b0, acc} - {1'b0, rhs};
            if (op == itc_pkg::OP_SUBC) begin
               wide = wide - {8'h00, carryIn};
            end
            result   = wide[7:0];
            carryOut = wide[8];
         end
         itc_pkg::OP_AND, itc_pkg::OP_AND_IMM: result = acc & rhs;
         itc_pkg::OP_OR,  itc_pkg::OP_OR_IMM:  result = acc | rhs;
         itc_pkg::OP_XOR, itc_pkg::OP_XOR_IMM: result = acc ^ rhs;
         itc_pkg::OP_COMPL:       result = ~mem;
         itc_pkg::OP_INC, itc_pkg::OP_SKIP_INC_ZERO: result = mem + 8'h01;
         itc_pkg::OP_DEC, itc_pkg::OP_SKIP_DEC_ZERO: result = mem - 8'h01;
         itc_pkg::OP_ROT_R:       result = {mem[0], mem[7:1]};
         itc_pkg::OP_ROT_L:       result = {mem[6:0], mem[7]};
         itc_pkg::OP_ROT_RC: begin
            result   = {carryIn, mem[7:1]};
            carryOut = mem[0];
         end
         itc_pkg::OP_ROT_LC: begin
            result   = {mem[6:0], carryIn};
            carryOut = mem[7];
         end
         itc_pkg::OP_BIT_CLR:     result = mem & ~mask;
         itc_pkg::OP_BIT_SET:     result = mem | mask;
         default:                 result = mem;
      endcase
   end
endmodule : itc_alu

// ==== hdl/itc_core.sv ====
// Instruction cycle core: fetch, decode, execute, flow control
// Assumes program and data memories answer combinationally to their
// address within one system clock; both sit on this same clock
`timescale 1ns/1ps
module itc_core #(
   parameter int STACK_DEPTH = itc_pkg::STACK_DEPTH
) (
   input  wire logic                        clk,
   input  wire logic                        nrst,
   output logic [itc_pkg::PC_W-1:0]         pmAddr,
   input  wire logic [itc_pkg::INSTR_W-1:0] pmData,
   output logic [itc_pkg::DATA_W-1:0]       dmAddr,
   input  wire logic [itc_pkg::DATA_W-1:0]  dmRdData,
   output logic [itc_pkg::DATA_W-1:0]       dmWrData,
   output logic                             dmWe,
   output logic [itc_pkg::DATA_W-1:0]       acc,
   output logic                             zeroFlag,
   output logic                             carryFlag,
   output logic                             intEnable,
   output logic                             retire
);
   localparam int SP_W = (STACK_DEPTH > 1) ? $clog2(STACK_DEPTH) : 1;

   itc_pkg::itc_phase_t          phase;
   itc_pkg::itc_op_t             op;
   logic [itc_pkg::INSTR_W-1:0]  instr;
   logic                         valid;
   logic [itc_pkg::PC_W-1:0]     pc;
   logic [7:0]                   operand;
   logic [7:0]                   tblPtr;
   logic [7:0]                   tblHigh;
   logic [itc_pkg::INSTR_W-1:0]  tblWord;
   logic [itc_pkg::PC_W-1:0]     stack [STACK_DEPTH];
   logic [SP_W-1:0]              sp;
   logic [SP_W-1:0]              spTop;
   logic                         redirect;
   logic [itc_pkg::PC_W-1:0]     target;

   // Decoded fields
   logic [2:0]                   sub;
   logic                         dest;
   logic [2:0]                   bitIdx;
   logic [7:0]                   imm;
   logic [itc_pkg::PC_W-1:0]     jumpAddr;

   // Decode results
   logic                         toAcc;
   logic                         toMem;
   logic                         setZ;
   logic                         setC;
   logic                         skip;
   logic                         jump;
   logic                         push;
   logic                         pop;
   logic                         tableRd;
   logic                         gieSet;
   logic [7:0]                   readVal;
   logic [7:0]                   aluRes;
   logic                         aluCarry;
   logic [7:0]                   wrVal;
   logic                         pcLowWr;
   logic                         next_redirect;
   logic [itc_pkg::PC_W-1:0]     next_target;

   ////////////////////////////////////////////////////////////////////////
   // Phase generator and data path
   itc_phase_gen u_phase (
      .clk   (clk),
      .nrst  (nrst),
      .phase (phase)
   );

   itc_alu u_alu (
      .op       (op),
      .acc      (acc),
      .mem      (operand),
      .imm      (imm),
      .bitIdx   (bitIdx),
      .carryIn  (carryFlag),
      .result   (aluRes),
      .carryOut (aluCarry)
   );

   // Instruction fields
   assign op       = itc_pkg::itc_op_t'(instr[itc_pkg::OP_MSB:itc_pkg::OP_LSB]);
   assign sub      = instr[itc_pkg::SUB_MSB:itc_pkg::SUB_LSB];
   assign dest     = instr[itc_pkg::DEST_POS];
   assign bitIdx   = instr[itc_pkg::BIT_MSB:itc_pkg::BIT_LSB];
   assign imm      = instr[itc_pkg::IMM_MSB:itc_pkg::IMM_LSB];
   assign jumpAddr = instr[itc_pkg::PC_W-1:0];
   assign spTop    = sp - SP_W'(1);

   ////////////////////////////////////////////////////////////////////////
   // Read path: core-held bytes override data memory
   always_comb begin
      case (dmAddr)
         itc_pkg::PC_LOW_ADDR:  readVal = pc[7:0];
         itc_pkg::TBL_PTR_ADDR: readVal = tblPtr;
         itc_pkg::TBL_HI_ADDR:  readVal = tblHigh;
         default:               readVal = dmRdData;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Decode: destination, flags and flow change
   always_comb begin
      toAcc   = 1'b0;
      toMem   = 1'b0;
      setZ    = 1'b0;
      setC    = 1'b0;
      skip    = 1'b0;
      jump    = 1'b0;
      push    = 1'b0;
      pop     = 1'b0;
      tableRd = 1'b0;
      gieSet  = 1'b0;
      case (op)
         itc_pkg::OP_SYS: begin
            case (sub)
               itc_pkg::SYS_RETURN:     pop = 1'b1;
               itc_pkg::SYS_INT_RETURN: begin
                  pop    = 1'b1;
                  gieSet = 1'b1;
               end
               itc_pkg::SYS_TABLE_READ: begin
                  tableRd = 1'b1;
                  toMem   = 1'b1;
               end
               itc_pkg::SYS_RETURN_IMM: begin
                  pop   = 1'b1;
                  toAcc = 1'b1;
               end
               default: pop = 1'b0;
            endcase
         end
         itc_pkg::OP_MOVE_TO_ACC, itc_pkg::OP_MOVE_IMM: toAcc = 1'b1;
         itc_pkg::OP_MOVE_TO_MEM: toMem = 1'b1;
         itc_pkg::OP_ADD, itc_pkg::OP_ADDC, itc_pkg::OP_SUB, itc_pkg::OP_SUBC: begin
            toMem = dest;
            toAcc = !dest;
            setZ  = 1'b1;
            setC  = 1'b1;
         end
         itc_pkg::OP_AND, itc_pkg::OP_OR, itc_pkg::OP_XOR, itc_pkg::OP_COMPL,
         itc_pkg::OP_INC, itc_pkg::OP_DEC: begin
            toMem = dest;
            toAcc = !dest;
            setZ  = 1'b1;
         end
         itc_pkg::OP_ROT_R, itc_pkg::OP_ROT_L: begin
            toMem = dest;
            toAcc = !dest;
         end
         itc_pkg::OP_ROT_RC, itc_pkg::OP_ROT_LC: begin
            toMem = dest;
            toAcc = !dest;
            setC  = 1'b1;
         end
         itc_pkg::OP_ADD_IMM, itc_pkg::OP_SUB_IMM: begin
            toAcc = 1'b1;
            setZ  = 1'b1;
            setC  = 1'b1;
         end
         itc_pkg::OP_AND_IMM, itc_pkg::OP_OR_IMM, itc_pkg::OP_XOR_IMM: begin
            toAcc = 1'b1;
            setZ  = 1'b1;
         end
         itc_pkg::OP_BIT_CLR, itc_pkg::OP_BIT_SET: toMem = 1'b1;
         itc_pkg::OP_SKIP_BIT_ZERO: skip = !operand[bitIdx];
         itc_pkg::OP_SKIP_BIT_SET:  skip = operand[bitIdx];
         itc_pkg::OP_SKIP_ZERO: begin
            toAcc = !dest;
            skip  = (operand == 8'h00);
         end
         itc_pkg::OP_SKIP_INC_ZERO, itc_pkg::OP_SKIP_DEC_ZERO: begin
            toMem = dest;
            toAcc = !dest;
            skip  = (aluRes == 8'h00);
         end
         itc_pkg::OP_JUMP: jump = 1'b1;
         itc_pkg::OP_CALL: begin
            jump = 1'b1;
            push = 1'b1;
         end
         default: jump = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Flow change: which word follows, and whether the fetch is dropped
   assign wrVal   = tableRd ? tblWord[7:0] : aluRes;
   assign pcLowWr = toMem && (dmAddr == itc_pkg::PC_LOW_ADDR);

   always_comb begin
      next_redirect = valid && (jump || pop || skip || tableRd || pcLowWr);
      next_target   = pc;                       // table read refetches
      if (jump) begin
         next_target = jumpAddr;
      end else if (pop) begin
         next_target = stack[spTop];
      end else if (pcLowWr) begin
         next_target = {pc[itc_pkg::PC_W-1:8], wrVal};
      end else if (skip) begin
         next_target = pc + itc_pkg::PC_W'(1);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Fetch: end of the fourth phase loads the next word or a bubble
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         instr <= itc_pkg::NOP_WORD;
         valid <= 1'b0;
         pc    <= itc_pkg::PC_RST;
      end else if (phase == itc_pkg::PH3) begin
         if (redirect) begin
            instr <= itc_pkg::NOP_WORD;
            valid <= 1'b0;
            pc    <= target;
         end else begin
            instr <= pmData;
            valid <= 1'b1;
            pc    <= pc + itc_pkg::PC_W'(1);
         end
      end
   end

   // Program address: pc, borrowed by a table read in phase one
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pmAddr  <= itc_pkg::PC_RST;
         tblWord <= itc_pkg::NOP_WORD;
      end else begin
         case (phase)
            itc_pkg::PH0: begin
               if (valid && tableRd) begin
                  pmAddr <= {pc[itc_pkg::PC_W-1:8], tblPtr};
               end
            end
            itc_pkg::PH1: begin
               if (valid && tableRd) begin
                  tblWord <= pmData;
               end
               pmAddr <= pc;
            end
            itc_pkg::PH3: pmAddr <= redirect ? target : pc + itc_pkg::PC_W'(1);
            default:      pmAddr <= pmAddr;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Operand access: address in phase one, capture at its end
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         dmAddr  <= itc_pkg::DATA_RST;
         operand <= itc_pkg::DATA_RST;
      end else if (phase == itc_pkg::PH0) begin
         dmAddr <= imm;
      end else if (phase == itc_pkg::PH1) begin
         operand <= readVal;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Write back at the end of phase two; write strobe lives in phase three
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         dmWe     <= 1'b0;
         dmWrData <= itc_pkg::DATA_RST;
         retire   <= 1'b0;
      end else begin
         dmWe   <= (phase == itc_pkg::PH2) && valid && toMem && !pcLowWr &&
                   (dmAddr != itc_pkg::TBL_PTR_ADDR) &&
                   (dmAddr != itc_pkg::TBL_HI_ADDR);
         retire <= (phase == itc_pkg::PH2) && valid;
         if (phase == itc_pkg::PH2) begin
            dmWrData <= wrVal;
         end
      end
   end

   // Accumulator, flags and table registers
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         acc       <= itc_pkg::DATA_RST;
         zeroFlag  <= 1'b0;
         carryFlag <= 1'b0;
         intEnable <= 1'b0;
         tblPtr    <= itc_pkg::DATA_RST;
         tblHigh   <= itc_pkg::DATA_RST;
      end else if (phase == itc_pkg::PH2 && valid) begin
         if (toAcc) begin
            acc <= wrVal;
         end
         if (setZ) begin
            zeroFlag <= (aluRes == 8'h00);
         end
         if (setC) begin
            carryFlag <= aluCarry;
         end
         if (gieSet) begin
            intEnable <= 1'b1;
         end
         if (toMem && dmAddr == itc_pkg::TBL_PTR_ADDR) begin
            tblPtr <= wrVal;
         end
         if (toMem && dmAddr == itc_pkg::TBL_HI_ADDR) begin
            tblHigh <= wrVal;
         end
         if (tableRd) begin
            tblHigh <= tblWord[15:8];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Return stack: circular, oldest entry lost on overflow
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sp       <= '0;
         redirect <= 1'b0;
         target   <= itc_pkg::PC_RST;
      end else if (phase == itc_pkg::PH2) begin
         redirect <= next_redirect;
         target   <= next_target;
         if (valid && push) begin
            sp <= sp + SP_W'(1);
         end else if (valid && pop) begin
            sp <= spTop;
         end
      end
   end

   // Return address is the word after the call
   always_ff @(posedge clk) begin
      if (phase == itc_pkg::PH2 && valid && push) begin
         stack[sp] <= pc;
      end
   end
endmodule : itc_core

// ==== dv/itc_core_chk.sv ====
// Concurrent checks on the ports of the instruction cycle core
// Assumes one clock domain, nrst asynchronous and active low
`timescale 1ns/1ps
module itc_core_chk #(
   parameter int STACK_DEPTH = itc_pkg::STACK_DEPTH
) (
   input wire logic        clk,
   input wire logic        nrst,
   input wire logic [10:0] pmAddr,
   input wire logic [15:0] pmData,
   input wire logic [7:0]  dmAddr,
   input wire logic [7:0]  dmRdData,
   input wire logic [7:0]  dmWrData,
   input wire logic        dmWe,
   input wire logic [7:0]  acc,
   input wire logic        zeroFlag,
   input wire logic        carryFlag,
   input wire logic        intEnable,
   input wire logic        retire
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);

   // Three quiet clocks after a completion
   sequence quiet3;
      !retire[*3];
   endsequence
   // Next completion one or two instruction cycles later
   sequence nextRetire;
      ##[4:8] retire;
   endsequence

   ////////////////////////////////////////////////////////////
   cycle_spacing_a: assert property (retire |=> quiet3)
      else $error("completions closer than four clocks");
   cycle_bound_a: assert property (retire |-> nextRetire)
      else $error("no completion within two instruction cycles");
   write_phase_a: assert property (dmWe |-> retire)
      else $error("data write outside a completing cycle");
   write_pulse_a: assert property (dmWe |=> !dmWe)
      else $error("data write longer than one clock");
   pcl_guard_a: assert property (dmWe |-> dmAddr != itc_pkg::PC_LOW_ADDR)
      else $error("program counter low byte written to memory");
   acc_retire_a: assert property (!$stable(acc) |-> retire)
      else $error("accumulator changed outside a completion");
   flag_retire_a: assert property (!$stable({zeroFlag, carryFlag}) |-> retire)
      else $error("flags changed outside a completion");
   int_sticky_a: assert property (intEnable |=> intEnable)
      else $error("interrupt enable dropped");
   addr_hold_a: assert property (retire |-> $stable(dmAddr))
      else $error("data address moved during read-modify-write");
endmodule : itc_core_chk

bind itc_core itc_core_chk #(.STACK_DEPTH(STACK_DEPTH)) chk (
   .clk(clk), .nrst(nrst), .pmAddr(pmAddr), .pmData(pmData), .dmAddr(dmAddr),
   .dmRdData(dmRdData), .dmWrData(dmWrData), .dmWe(dmWe), .acc(acc),
   .zeroFlag(zeroFlag), .carryFlag(carryFlag), .intEnable(intEnable), .retire(retire)
);

// ==== dv/itc_mem_model.sv ====
// Program and data memories beside the core
// Assumes both answer combinationally on the core's clock
`timescale 1ns/1ps
module itc_mem_model (
   input wire logic        clk,
   input wire logic [10:0] pmAddr,
   output logic [15:0]     pmData,
   input wire logic [7:0]  dmAddr,
   output logic [7:0]      dmRdData,
   input wire logic [7:0]  dmWrData,
   input wire logic        dmWe
);
   logic [15:0] rom [0:2047];
   logic [7:0]  ram [0:255];

   // Combinational reads
   assign pmData   = rom[pmAddr];
   assign dmRdData = ram[dmAddr];

   // Byte write on the strobe
   always @(posedge clk) begin
      if (dmWe) begin
         ram[dmAddr] <= dmWrData;
      end
   end

   // Fill with no-operation words and zero bytes
   task automatic clear();
      foreach (rom[i]) rom[i] = 16'h0000;
      foreach (ram[i]) ram[i] = 8'h00;
   endtask : clear
endmodule : itc_mem_model

// ==== dv/itc_testbench.sv ====
// Self-checking bench of the instruction cycle core
// Assumes the memory model and the bound checker
`timescale 1ns/1ps
module testbench;
   logic        clk = 1'b0;
   logic        nrst = 1'b0;
   logic [10:0] pmAddr;
   logic [15:0] pmData;
   logic [7:0]  dmAddr;
   logic [7:0]  dmRdData;
   logic [7:0]  dmWrData;
   logic        dmWe;
   logic [7:0]  acc;
   logic        zeroFlag;
   logic        carryFlag;
   logic        intEnable;
   logic        retire;
   int          failures = 0;
   int          n_compared = 0;
   logic [7:0]  expAcc [$];
   int          expGap [$];
   logic [1:0]  expZc [$];

   always #5 clk = ~clk;

   itc_core dut (.clk(clk), .nrst(nrst), .pmAddr(pmAddr), .pmData(pmData),
      .dmAddr(dmAddr), .dmRdData(dmRdData), .dmWrData(dmWrData), .dmWe(dmWe),
      .acc(acc), .zeroFlag(zeroFlag), .carryFlag(carryFlag),
      .intEnable(intEnable), .retire(retire));
   itc_mem_model mem (.clk(clk), .pmAddr(pmAddr), .pmData(pmData), .dmAddr(dmAddr),
      .dmRdData(dmRdData), .dmWrData(dmWrData), .dmWe(dmWe));

   ////////////////////////////////////////////////////////////
   task automatic end_sim();
      if (failures == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : end_sim

   task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : check8

   // Program word at a, with what its completion must show
   task automatic step(input logic [10:0] a, input logic [15:0] w, input logic [7:0] ea,
                       input int gap, input logic [1:0] zc);
      mem.rom[a] = w;
      expAcc.push_back(ea);
      expGap.push_back(gap);
      expZc.push_back(zc);
   endtask : step

   // Reset, then judge each completion and its spacing
   task automatic run_prog(input logic chkZc);
      int gap;
      @(posedge clk);
      nrst <= 1'b0;
      repeat (16) @(posedge clk);
      nrst <= 1'b1;
      foreach (expAcc[i]) begin
         for (gap = 1; gap < 40; gap++) begin
            @(negedge clk);
            if (retire === 1'b1) break;
         end
         if (retire !== 1'b1) begin
            failures++;
            end_sim();
         end
         check8("acc", expAcc[i], acc);
         if (expGap[i] != 0) check8("cycle", expGap[i][7:0], 8'(gap));
         if (chkZc) check8("flags", {6'h00, expZc[i]}, {6'h00, zeroFlag, carryFlag});
      end
      expAcc.delete();
      expGap.delete();
      expZc.delete();
   endtask : run_prog

   // Data path: moves, arithmetic, logic, rotates, bit ops
   task automatic scen_alu();
      mem.clear();
      step(11'h000, 16'h1810, 8'h10, 0, 2'h0);
      step(11'h001, 16'h9811, 8'hFF, 4, 2'h1);
      step(11'h002, 16'h9001, 8'h00, 4, 2'h3);
      step(11'h003, 16'h1020, 8'h00, 4, 2'h3);
      step(11'h004, 16'h1881, 8'h81, 4, 2'h3);
      step(11'h005, 16'h1021, 8'h81, 4, 2'h3);
      step(11'h006, 16'hB081, 8'h00, 4, 2'h3);
      step(11'h007, 16'hA881, 8'h81, 4, 2'h1);
      step(11'h008, 16'h8020, 8'h80, 4, 2'h0);
      step(11'h009, 16'h7021, 8'hC0, 4, 2'h0);
      step(11'h00A, 16'h8821, 8'h02, 4, 2'h1);
      step(11'h00B, 16'h6421, 8'h02, 4, 2'h1);
      step(11'h00C, 16'h6820, 8'hFF, 4, 2'h1);
      step(11'h00D, 16'h5821, 8'h7D, 4, 2'h1);
      step(11'h00E, 16'hA000, 8'h00, 4, 2'h3);
      step(11'h00F, 16'hC720, 8'h00, 4, 2'h3);
      step(11'h010, 16'hB921, 8'h00, 4, 2'h3);
      step(11'h011, 16'h0820, 8'h80, 4, 2'h3);
      step(11'h012, 16'h2020, 8'h00, 4, 2'h3);
      step(11'h013, 16'h2820, 8'h81, 4, 2'h0);
      step(11'h014, 16'h3021, 8'h01, 4, 2'h0);
      step(11'h015, 16'h3020, 8'h81, 4, 2'h1);
      step(11'h016, 16'h3820, 8'h00, 4, 2'h2);
      step(11'h017, 16'h5020, 8'h80, 4, 2'h0);
      step(11'h018, 16'h4C22, 8'h80, 4, 2'h0);
      step(11'h019, 16'h4023, 8'h00, 4, 2'h2);
      step(11'h01A, 16'h7820, 8'h01, 4, 2'h2);
      run_prog(1'b1);
      @(posedge clk);
      check8("mem21", 8'h80, mem.ram[8'h21]);
      check8("mem22", 8'h80, mem.ram[8'h22]);
   endtask : scen_alu

   // Flow: call, return, jump, skips, counter writes, table read
   task automatic scen_flow();
      mem.clear();
      mem.rom[11'h003] = 16'h18EE;
      mem.rom[11'h022] = 16'h18EE;
      mem.rom[11'h060] = 16'hA55A;
      mem.rom[11'h049] = 16'h18EE;
      step(11'h000, 16'hF810, 8'h00, 0, 2'h0);
      step(11'h010, 16'h1822, 8'h22, 8, 2'h0);
      step(11'h011, 16'h0100, 8'h22, 4, 2'h0);
      step(11'h001, 16'h1811, 8'h11, 8, 2'h0);
      step(11'h002, 16'hF020, 8'h11, 4, 2'h0);
      step(11'h020, 16'hD030, 8'h11, 8, 2'h0);
      step(11'h021, 16'hC830, 8'h11, 4, 2'h0);
      step(11'h023, 16'h1833, 8'h33, 8, 2'h0);
      step(11'h024, 16'h1840, 8'h40, 4, 2'h0);
      step(11'h025, 16'h1006, 8'h40, 4, 2'h0);
      step(11'h040, 16'h1844, 8'h44, 8, 2'h0);
      step(11'h041, 16'hF850, 8'h44, 4, 2'h0);
      step(11'h050, 16'h0200, 8'h44, 8, 2'h0);
      step(11'h042, 16'h1860, 8'h60, 8, 2'h0);
      step(11'h043, 16'h1007, 8'h60, 4, 2'h0);
      step(11'h044, 16'h0331, 8'h60, 4, 2'h0);
      step(11'h045, 16'h0808, 8'hA5, 8, 2'h0);
      step(11'h046, 16'hD831, 8'h5A, 4, 2'h0);
      step(11'h047, 16'hE432, 8'h5A, 4, 2'h0);
      step(11'h048, 16'hE832, 8'h00, 4, 2'h0);
      step(11'h04A, 16'hF870, 8'h00, 8, 2'h0);
      step(11'h070, 16'h043C, 8'h3C, 8, 2'h0);
      step(11'h04B, 16'hF04B, 8'h3C, 8, 2'h0);
      run_prog(1'b0);
      check8("mem31", 8'h5A, mem.ram[8'h31]);
      check8("mem06", 8'h00, mem.ram[8'h06]);
      check8("intEnable", 8'h01, {7'h00, intEnable});
      check8("mem32", 8'h01, mem.ram[8'h32]);
   endtask : scen_flow

   initial begin
      scen_alu();
      scen_flow();
      end_sim();
   end
endmodule : testbench
